// ### common/hsts_brk_if.sv
// Signals between the sequencer top and its breaker timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface hsts_brk_if;
    logic both_lim;   // Both gate channels in current limit
    logic at_hi;      // Timer at upper threshold
    logic at_lo;      // Timer below lower threshold
    logic charge;     // Select charging source
    logic discharge;  // Select discharging sink
    logic oc_event;   // One-cycle overcurrent trip
    logic busy;       // Post-fault discharge or cool-down under way

    modport ctl (output both_lim, at_hi, at_lo, input charge, discharge, oc_event, busy);
    modport brk (input both_lim, at_hi, at_lo, output charge, discharge, oc_event, busy);
endinterface

// ### common/hsts_defs.svh
// Constants of the hot swap turn-off and fault sequencer.
// Assumes inclusion by bare name from package and design files.
`ifndef HSTS_DEFS_SVH
`define HSTS_DEFS_SVH

// Register offsets
`define HSTS_ADDR_CTL       8'h00
`define HSTS_ADDR_FAULT     8'h04
`define HSTS_ADDR_TRIM      8'h11
`define HSTS_ADDR_STATUS    8'h1E

// Control register fields
`define HSTS_CTL_OV_RETRY   0
`define HSTS_CTL_UV_RETRY   1
`define HSTS_CTL_OC_RETRY   2
`define HSTS_CTL_GATE_EN    3
`define HSTS_CTL_ON_POL     5
`define HSTS_CTL_ON_MASK    7

// Fault record fields
`define HSTS_FLT_OV         0
`define HSTS_FLT_UV         1
`define HSTS_FLT_OC         2
`define HSTS_FLT_PBAD       3
`define HSTS_FLT_ON         4
`define HSTS_FLT_FETBAD     6
`define HSTS_FLT_RESET      8'h00

// Status register fields
`define HSTS_ST_OV          0
`define HSTS_ST_UV          1
`define HSTS_ST_FETBAD      2
`define HSTS_ST_PGOOD       3
`define HSTS_ST_ON          4
`define HSTS_ST_FAST        5

// Current limit trim field
`define HSTS_TRIM_HI        7
`define HSTS_TRIM_LO        5

// Synchronised comparator vector positions
`define HSTS_S_ON           0
`define HSTS_S_OV           1
`define HSTS_S_UV           2
`define HSTS_S_FETBAD       3
`define HSTS_S_ILIM1        4
`define HSTS_S_ILIM2        5
`define HSTS_S_TMR_HI       6
`define HSTS_S_TMR_LO       7
`define HSTS_S_FB           8
`define HSTS_S_GS1          9
`define HSTS_S_GS2          10
`define HSTS_S_VDD_UV       11
`define HSTS_S_ICC_UV       12
`define HSTS_S_WIDTH        13

// Timing
`define HSTS_CLK_NS         20
`define HSTS_FAST_NS        2000
`define HSTS_COOL_COUNT     256

`endif

// ### common/hsts_pkg.sv
// Types shared by the sequencer modules.
// Assumes hsts_defs.svh on the include path.
`include "hsts_defs.svh"

package hsts_pkg;
    // One register byte
    typedef logic [7:0] hsts_byte_t;

    // Breaker timer sequence states
    typedef enum logic [2:0] {
        HSTS_BRK_IDLE,
        HSTS_BRK_CHARGE,
        HSTS_BRK_BLEED,
        HSTS_BRK_FAULT_DOWN,
        HSTS_BRK_COOL_UP,
        HSTS_BRK_COOL_DOWN
    } hsts_brk_state_t;
endpackage

// ### hw/hsts_breaker.sv
// Breaker timer sequencer: selects charge or discharge of the timer
// capacitor and counts the cool-down. Assumes synchronised inputs.
`timescale 1ns/1ps
`include "hsts_defs.svh"

module hsts_breaker
    import hsts_pkg::*;
#(
    parameter int COOL_CYCLES = `HSTS_COOL_COUNT
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Link to the top
    hsts_brk_if.brk   bif
);
    hsts_brk_state_t state_q;   // Sequence state
    logic [15:0]     cool_q;    // Completed cool-down cycles

    // Counter must hold the count
    if (COOL_CYCLES < 1 || COOL_CYCLES > 65535) begin : g_chk
        $error("hsts_breaker: COOL_CYCLES out of range");
    end

    // State sequence
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= HSTS_BRK_IDLE;
        end else begin
            case (state_q)
                HSTS_BRK_IDLE: begin
                    if (bif.both_lim) state_q <= HSTS_BRK_CHARGE;
                end
                HSTS_BRK_CHARGE: begin
                    if (bif.at_hi) state_q <= HSTS_BRK_FAULT_DOWN;
                    else if (!bif.both_lim) state_q <= HSTS_BRK_BLEED;
                end
                HSTS_BRK_BLEED: begin
                    if (bif.both_lim) state_q <= HSTS_BRK_CHARGE;
                    else if (bif.at_lo) state_q <= HSTS_BRK_IDLE;
                end
                HSTS_BRK_FAULT_DOWN: begin
                    if (bif.at_lo) state_q <= HSTS_BRK_COOL_UP;
                end
                HSTS_BRK_COOL_UP: begin
                    if (bif.at_hi) state_q <= HSTS_BRK_COOL_DOWN;
                end
                HSTS_BRK_COOL_DOWN: begin
                    // Last fall ends the cool-down
                    if (bif.at_lo) begin
                        state_q <= (cool_q == 16'(COOL_CYCLES - 1)) ? HSTS_BRK_IDLE : HSTS_BRK_COOL_UP;
                    end
                end
                default: state_q <= HSTS_BRK_IDLE;
            endcase
        end
    end

    // Cool-down counter, cleared at every trip
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cool_q <= '0;
        end else if (state_q == HSTS_BRK_CHARGE && bif.at_hi) begin
            cool_q <= '0;
        end else if (state_q == HSTS_BRK_COOL_DOWN && bif.at_lo) begin
            cool_q <= cool_q + 16'h0001;
        end
    end

    // Registered source selects and trip pulse
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bif.charge    <= 1'b0;
            bif.discharge <= 1'b0;
            bif.oc_event  <= 1'b0;
            bif.busy      <= 1'b0;
        end else begin
            bif.oc_event <= (state_q == HSTS_BRK_CHARGE) && bif.at_hi;
            bif.busy     <= (state_q == HSTS_BRK_FAULT_DOWN) || (state_q == HSTS_BRK_COOL_UP)
                            || (state_q == HSTS_BRK_COOL_DOWN) || ((state_q == HSTS_BRK_CHARGE) && bif.at_hi);
            bif.charge    <= (state_q == HSTS_BRK_CHARGE && !bif.at_hi && bif.both_lim)
                             || (state_q == HSTS_BRK_IDLE && bif.both_lim)
                             || (state_q == HSTS_BRK_BLEED && bif.both_lim)
                             || (state_q == HSTS_BRK_COOL_UP && !bif.at_hi)
                             || (state_q == HSTS_BRK_FAULT_DOWN && bif.at_lo)
                             || (state_q == HSTS_BRK_COOL_DOWN && bif.at_lo
                                 && cool_q != 16'(COOL_CYCLES - 1));
            bif.discharge <= (state_q == HSTS_BRK_CHARGE && (bif.at_hi || !bif.both_lim))
                             || (state_q == HSTS_BRK_BLEED && !bif.both_lim && !bif.at_lo)
                             || (state_q == HSTS_BRK_FAULT_DOWN && !bif.at_lo)
                             || (state_q == HSTS_BRK_COOL_UP && bif.at_hi)
                             || (state_q == HSTS_BRK_COOL_DOWN && !bif.at_lo);
        end
    end
endmodule

// ### hw/hsts_sync.sv
// Two-flop synchroniser for a vector of comparator levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps

module hsts_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;  // First stage, read only by second

    // Width check
    if (W < 1) begin : g_chk
        $error("hsts_sync: W must be at least 1");
    end

    // Two stages, nothing taps the first
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// ### hw/hsts_top.sv
// Hot swap turn-off and fault sequencer: gate enables and pull-downs,
// fault record, breaker timer, power good and trim register.
// Assumes comparator levels arrive on inputs and a decoded register port.
`timescale 1ns/1ps
`include "hsts_defs.svh"

module hsts_top
    import hsts_pkg::*;
#(
    parameter int FAST_CYCLES = (`HSTS_FAST_NS + `HSTS_CLK_NS - 1) / `HSTS_CLK_NS,
    parameter int COOL_CYCLES = `HSTS_COOL_COUNT
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Nonvolatile power-up defaults
    input  wire hsts_byte_t nv_control_i,
    input  wire hsts_byte_t nv_trim_i,
    // Comparators and sense inputs
    input  wire logic       on_pin_i,
    input  wire logic       input_overvoltage_i,
    input  wire logic       input_undervoltage_i,
    input  wire logic       mosfet_bad_i,
    input  wire logic       ilim1_active_i,
    input  wire logic       ilim2_active_i,
    input  wire logic       timer_at_hi_i,
    input  wire logic       timer_below_lo_i,
    input  wire logic       output_feedback_ok_i,
    input  wire logic       gs1_above_i,
    input  wire logic       gs2_above_i,
    input  wire logic       vdd_uvlo_i,
    input  wire logic       internal_supply_uv_i,
    // Static configuration
    input  wire logic       pg_mode_i,
    input  wire logic       fetbad_retry_i,
    // Register port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire hsts_byte_t reg_addr_i,
    input  wire hsts_byte_t reg_wdata_i,
    output hsts_byte_t      reg_rdata_o,
    // Gate drive
    output logic            gate_pullup_o,
    output logic            gate_pd_slow_o,
    output logic            gate_pd_fast_o,
    // Timer current selects
    output logic            timer_charge_o,
    output logic            timer_discharge_o,
    // Limit trim code
    output logic [2:0]      ilim_sel_o,
    // Power-good pin, open drain
    output logic            power_good_pin_o,
    output logic            power_good_pin_oe_o
);
    logic [`HSTS_S_WIDTH-1:0] s;        // Synchronised comparators
    hsts_byte_t  ctl_q;                 // Control settings
    hsts_byte_t  fault_q;               // Fault record
    hsts_byte_t  trim_q;                // Current-limit trim
    hsts_byte_t  ctl_d;
    hsts_byte_t  fault_d;
    logic        follow_on_q;           // Pin edges act on enable
    logic        on_act_q;              // Last active-level on input
    logic        on_act;
    logic        on_rise;
    logic        on_fall;
    logic        on_toggle;
    logic [15:0] fast_cnt_q;            // Supply-low duration
    logic        fast_q;                // Fast shutdown engaged
    logic        fast_d;
    logic        supply_low;
    logic        latched_off;
    logic        gate_allow;
    logic        gate_on_q;             // Gates being enhanced
    logic        pgood_q;               // Power good
    logic        pgood_d;
    logic        pbad_evt;
    logic        wr_ctl;
    logic        wr_fault;
    logic        wr_trim;
    hsts_brk_if  bif ();                // Link to the breaker timer

    // Counter width must cover the qualification time
    if (FAST_CYCLES < 1 || FAST_CYCLES > 65534) begin : g_chk
        $error("hsts_top: FAST_CYCLES out of range");
    end

    // Address decode, shared by writes below
    function automatic logic hit(input hsts_byte_t a, input hsts_byte_t off);
        hit = (a == off);
    endfunction

    // Every comparator is resynchronised before any use
    hsts_sync #(
        .W (`HSTS_S_WIDTH)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({internal_supply_uv_i, vdd_uvlo_i, gs2_above_i, gs1_above_i,
                     output_feedback_ok_i, timer_below_lo_i, timer_at_hi_i,
                     ilim2_active_i, ilim1_active_i, mosfet_bad_i,
                     input_undervoltage_i, input_overvoltage_i, on_pin_i}),
        .sync_o    (s)
    );

    // Breaker timer machine
    hsts_breaker #(
        .COOL_CYCLES (COOL_CYCLES)
    ) u_brk (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .bif       (bif.brk)
    );

    // Timer fault ramp only starts when both channels are limiting together
    assign bif.both_lim = s[`HSTS_S_ILIM1] & s[`HSTS_S_ILIM2];
    assign bif.at_hi    = s[`HSTS_S_TMR_HI];
    assign bif.at_lo    = s[`HSTS_S_TMR_LO];

    // Write strobes
    assign wr_ctl   = reg_wr_i && hit(reg_addr_i, `HSTS_ADDR_CTL);
    assign wr_fault = reg_wr_i && hit(reg_addr_i, `HSTS_ADDR_FAULT);
    assign wr_trim  = reg_wr_i && hit(reg_addr_i, `HSTS_ADDR_TRIM);

    // On input in its configured polarity
    assign on_act    = ctl_q[`HSTS_CTL_ON_POL] ? s[`HSTS_S_ON] : ~s[`HSTS_S_ON];
    assign on_rise   = on_act & ~on_act_q;
    assign on_fall   = ~on_act & on_act_q;
    assign on_toggle = s[`HSTS_S_ON] ^ (ctl_q[`HSTS_CTL_ON_POL] ? on_act_q : ~on_act_q);

    // Previous on level, for edge detection
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            on_act_q <= ~nv_control_i[`HSTS_CTL_ON_POL];
        end else begin
            on_act_q <= on_act;
        end
    end

    // Whether pin edges may move the enable is fixed at power-up
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            follow_on_q <= nv_control_i[`HSTS_CTL_GATE_EN];
        end else begin
            follow_on_q <= follow_on_q;
        end
    end

    // Control next value: host write, then pin edges win
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = reg_wdata_i;
        end
        if (follow_on_q && on_rise) begin
            ctl_d[`HSTS_CTL_GATE_EN] = 1'b1;
        end else if (follow_on_q && on_fall) begin
            ctl_d[`HSTS_CTL_GATE_EN] = 1'b0;
        end
    end

    // Control register, loaded from nonvolatile defaults
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctl_q <= nv_control_i;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Trim register; host may change it any time
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            trim_q <= nv_trim_i;
        end else if (wr_trim) begin
            trim_q <= reg_wdata_i;
        end
    end

    // Trim code to the sense level selector
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ilim_sel_o <= nv_trim_i[`HSTS_TRIM_HI:`HSTS_TRIM_LO];
        end else begin
            ilim_sel_o <= (wr_trim ? reg_wdata_i[`HSTS_TRIM_HI:`HSTS_TRIM_LO]
                                   : trim_q[`HSTS_TRIM_HI:`HSTS_TRIM_LO]);
        end
    end

    // Power-bad only when good power is lost with gates on;
    // a start-up never had good power, so it cannot fault
    assign pbad_evt = pgood_q & ~s[`HSTS_S_FB] & gate_on_q;

    // Fault record: write, on-toggle clear, then sets win
    always_comb begin
        fault_d = fault_q;
        if (wr_fault) begin
            fault_d = reg_wdata_i;
        end
        if (on_toggle && !ctl_q[`HSTS_CTL_ON_MASK]) begin
            fault_d = fault_d & (8'h01 << `HSTS_FLT_ON);
        end
        // Set beats a clear in the same cycle
        fault_d[`HSTS_FLT_OV]     = fault_d[`HSTS_FLT_OV] | s[`HSTS_S_OV];
        fault_d[`HSTS_FLT_UV]     = fault_d[`HSTS_FLT_UV] | s[`HSTS_S_UV];
        fault_d[`HSTS_FLT_OC]     = fault_d[`HSTS_FLT_OC] | bif.oc_event;
        fault_d[`HSTS_FLT_PBAD]   = fault_d[`HSTS_FLT_PBAD] | pbad_evt;
        fault_d[`HSTS_FLT_ON]     = fault_d[`HSTS_FLT_ON] | on_toggle;
        fault_d[`HSTS_FLT_FETBAD] = fault_d[`HSTS_FLT_FETBAD] | s[`HSTS_S_FETBAD];
    end

    // Fault record, empty after reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fault_q <= `HSTS_FLT_RESET;
        end else begin
            fault_q <= fault_d;
        end
    end

    // Supply-low duration; fast shutdown once it exceeds the limit
    assign supply_low = s[`HSTS_S_VDD_UV] | s[`HSTS_S_ICC_UV];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fast_cnt_q <= '0;
        end else if (!supply_low) begin
            fast_cnt_q <= '0;
        end else if (fast_cnt_q != 16'(FAST_CYCLES)) begin
            fast_cnt_q <= fast_cnt_q + 16'h0001;
        end
    end

    // Qualified supply loss; gates see it at the same edge as the fast path
    assign fast_d = supply_low && (fast_cnt_q == 16'(FAST_CYCLES));

    // Fast shutdown holds for as long as the supply stays low
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fast_q <= 1'b0;
        end else begin
            fast_q <= fast_d;
        end
    end
    assign gate_pd_fast_o = fast_q;

    // A set fault bit with its retry off keeps the gates down
    assign latched_off = (fault_q[`HSTS_FLT_OV] & ~ctl_q[`HSTS_CTL_OV_RETRY])
                       | (fault_q[`HSTS_FLT_UV] & ~ctl_q[`HSTS_CTL_UV_RETRY])
                       | (fault_q[`HSTS_FLT_OC] & ~ctl_q[`HSTS_CTL_OC_RETRY])
                       | (fault_q[`HSTS_FLT_FETBAD] & ~fetbad_retry_i);

    // Gates run only with enable set and no fault or cool-down;
    // a retrying fault still holds them off while it is present
    assign gate_allow = ctl_q[`HSTS_CTL_GATE_EN]
                      & ~latched_off
                      & ~s[`HSTS_S_OV] & ~s[`HSTS_S_UV] & ~s[`HSTS_S_FETBAD]
                      & ~bif.oc_event & ~bif.busy
                      & ~fast_d;

    // Gate drive: pull-up when allowed, 1mA pull-down otherwise;
    // the fast path takes over at the same edge, never overlapping
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            gate_on_q      <= 1'b0;
            gate_pd_slow_o <= 1'b1;
        end else begin
            gate_on_q      <= gate_allow;
            gate_pd_slow_o <= ~gate_allow & ~fast_d;
        end
    end
    assign gate_pullup_o = gate_on_q;

    // Timer current selects pass straight from the breaker flops
    assign timer_charge_o    = bif.charge;
    assign timer_discharge_o = bif.discharge;

    // Power good needs feedback and both gate drives enhanced
    assign pgood_d = s[`HSTS_S_FB] & s[`HSTS_S_GS1] & s[`HSTS_S_GS2] & gate_on_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pgood_q <= 1'b0;
        end else begin
            pgood_q <= pgood_d;
        end
    end

    // Open-drain pin pulls low when power is not good
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            power_good_pin_o    <= 1'b0;
            power_good_pin_oe_o <= 1'b0;
        end else begin
            power_good_pin_o    <= 1'b0;
            power_good_pin_oe_o <= pg_mode_i & ~pgood_d;
        end
    end

    // Read data one edge after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `HSTS_ADDR_CTL:    reg_rdata_o <= ctl_q;
                `HSTS_ADDR_FAULT:  reg_rdata_o <= fault_q;
                `HSTS_ADDR_TRIM:   reg_rdata_o <= trim_q;
                `HSTS_ADDR_STATUS: begin
                    reg_rdata_o                  <= 8'h00;
                    reg_rdata_o[`HSTS_ST_OV]     <= s[`HSTS_S_OV];
                    reg_rdata_o[`HSTS_ST_UV]     <= s[`HSTS_S_UV];
                    reg_rdata_o[`HSTS_ST_FETBAD] <= s[`HSTS_S_FETBAD];
                    reg_rdata_o[`HSTS_ST_PGOOD]  <= pgood_q;
                    reg_rdata_o[`HSTS_ST_ON]     <= on_act;
                    reg_rdata_o[`HSTS_ST_FAST]   <= fast_q;
                end
                default:           reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ### verif/hsts_timer_model.sv
// Timer capacitor model: ramps up fast, bleeds slowly.
// Assumes the sequencer clock and its registered selects.
`timescale 1ns/1ps
module hsts_timer_model (
    // Clock and selects
    input  wire logic clk_i,
    input  wire logic charge_i,
    input  wire logic discharge_i,
    // Comparator levels
    output logic      at_hi_o,
    output logic      below_lo_o
);
    int lvl = 0; // Charge is four times the bleed, as 20uA to 5uA
    // Level moves only under a select
    always @(posedge clk_i) begin
        if (charge_i && lvl < 64) begin
            lvl <= lvl + 4;
        end else if (discharge_i && lvl > 0) begin
            lvl <= lvl - 1;
        end
    end
    assign at_hi_o    = (lvl >= 64);
    assign below_lo_o = (lvl < 8);
endmodule

// ### verif/hsts_top_bench.sv
// Self-checking sequencer bench with a timer model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module hsts_top_bench;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, on = 1'b0, ov = 1'b0, uv = 1'b0, fbad = 1'b0, il1 = 1'b0;
    logic il2 = 1'b0, fb = 1'b0, gs1 = 1'b0, gs2 = 1'b0, vuv = 1'b0, iuv = 1'b0, wr = 1'b0, rd = 1'b0;
    logic hi, lo, pu, pds, pdf, chg, dis, pgo, pgoe;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat, trim, nvt = 8'h00, trips = 8'h00;
    logic [2:0] sel;
    int errors = 0, checks = 0, seed = 21890, i;
    always #10 clk_i = ~clk_i;
    always @(posedge chg) trips++; // Charge ramps seen
    hsts_top #(.FAST_CYCLES(100), .COOL_CYCLES(2)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .nv_control_i(8'hAF), .nv_trim_i(nvt), .on_pin_i(on),
        .input_overvoltage_i(ov), .input_undervoltage_i(uv), .mosfet_bad_i(fbad), .ilim1_active_i(il1),
        .ilim2_active_i(il2), .timer_at_hi_i(hi), .timer_below_lo_i(lo), .output_feedback_ok_i(fb),
        .gs1_above_i(gs1), .gs2_above_i(gs2), .vdd_uvlo_i(vuv), .internal_supply_uv_i(iuv), .pg_mode_i(1'b1),
        .fetbad_retry_i(1'b1), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .gate_pullup_o(pu), .gate_pd_slow_o(pds), .gate_pd_fast_o(pdf),
        .timer_charge_o(chg), .timer_discharge_o(dis), .ilim_sel_o(sel), .power_good_pin_o(pgo),
        .power_good_pin_oe_o(pgoe));
    hsts_timer_model i_tmr (.clk_i(clk_i), .charge_i(chg), .discharge_i(dis), .at_hi_o(hi), .below_lo_o(lo));
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask
    // One access, strobe held over one rising edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        @(negedge clk_i);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        tick(1);
        check(rdat & m, e);
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        summarize();
    end
    initial begin
        nvt = $random(seed);
        tick(2);
        sys_rst_i = 1'b0;
        chk1(pgo, 1'b0);
        check(sel, nvt[7:5]);
        rc(8'h11, 8'hFF, nvt);
        rc(8'h00, 8'hFF, 8'hAF);
        rc(8'h5A, 8'hFF, 8'h00);
        on = 1'b1;
        fb = 1'b1;
        tick(6);
        chk1(pu, 1'b1);
        gs1 = 1'b1;
        gs2 = 1'b1;
        tick(5);
        chk1(pgoe, 1'b0);
        rc(8'h1E, 8'h08, 8'h08);
        rc(8'h04, 8'h08, 8'h00);
        gs2 = 1'b0;
        tick(5);
        chk1(pgoe, 1'b1);
        gs2 = 1'b1;
        for (i = 0; i < 8; i++) begin
            trim = (i == 0) ? 8'hE0 : $random(seed);
            acc(1'b1, 8'h11, trim);
            check(sel, trim[7:5]);
            rc(8'h11, 8'hFF, trim);
        end
        acc(1'b1, 8'h00, 8'hA7);
        tick(3);
        chk1(pu, 1'b0);
        acc(1'b1, 8'h00, 8'hAF);
        for (i = 0; i < 3; i++) begin
            {fbad, uv, ov} = 3'b001 << i;
            tick(5);
            chk1(pu, 1'b0);
            rc(8'h04, 8'h43, (i == 2) ? 8'h40 : 8'h01 << i);
            {fbad, uv, ov} = 3'b000;
            tick(6);
            chk1(pu, 1'b1);
            acc(1'b1, 8'h04, 8'h00);
        end
        acc(1'b1, 8'h00, 8'hAE);
        ov = 1'b1;
        tick(5);
        ov = 1'b0;
        tick(6);
        chk1(pu, 1'b0);
        acc(1'b1, 8'h04, 8'h00);
        tick(4);
        chk1(pu, 1'b1);
        acc(1'b1, 8'h00, 8'hAF);
        on = 1'b0;
        tick(5);
        chk1(pu, 1'b0);
        rc(8'h00, 8'h08, 8'h00);
        on = 1'b1;
        tick(5);
        rc(8'h00, 8'h08, 8'h08);
        il1 = 1'b1;
        il2 = 1'b1;
        tick(6);
        chk1(chg, 1'b1);
        il2 = 1'b0;
        tick(4);
        chk1(dis, 1'b1);
        tick(40);
        trips = 8'h00;
        il2 = 1'b1;
        for (i = 0; i < 100 && pu; i++) tick(1);
        il1 = 1'b0;
        il2 = 1'b0;
        rc(8'h04, 8'h04, 8'h04);
        for (i = 0; i < 2000 && !pu; i++) tick(1);
        chk1(pu, 1'b1);
        check(trips, 8'h03);
        vuv = 1'b1;
        tick(90);
        chk1(pdf, 1'b0);
        tick(20);
        chk1(pdf, 1'b1);
        vuv = 1'b0;
        iuv = 1'b1;
        tick(110);
        chk1(pds, 1'b0);
        iuv = 1'b0;
        tick(5);
        chk1(pdf, 1'b0);
        fb = 1'b0;
        tick(5);
        chk1(pgoe, 1'b1);
        summarize();
    end
endmodule

// ### verif/hsts_top_chk.sv
// Checker of the sequencer top ports.
// Assumes a bind onto hsts_top with its parameters.
`timescale 1ns/1ps
module hsts_top_chk
    import hsts_pkg::*;
#(
    parameter int FAST_CYCLES = 100
) (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // Watched inputs
    input wire logic       input_overvoltage_i,
    input wire logic       input_undervoltage_i,
    input wire logic       mosfet_bad_i,
    input wire logic       timer_at_hi_i,
    input wire logic       output_feedback_ok_i,
    input wire logic       vdd_uvlo_i,
    input wire logic       internal_supply_uv_i,
    input wire logic       pg_mode_i,
    input wire logic       reg_wr_i,
    input wire hsts_byte_t reg_addr_i,
    input wire hsts_byte_t reg_wdata_i,
    // Watched outputs
    input wire logic       gate_pullup_o,
    input wire logic       gate_pd_slow_o,
    input wire logic       gate_pd_fast_o,
    input wire logic       timer_charge_o,
    input wire logic [2:0] ilim_sel_o,
    input wire logic       power_good_pin_oe_o
);
    logic [7:0] low_q; // Raw supply-low run length, saturating
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !(vdd_uvlo_i || internal_supply_uv_i)) begin
            low_q <= 8'h00;
        end else if (low_q != 8'hFF) begin
            low_q <= low_q + 8'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    pull_mode_a: assert property (gate_pd_slow_o == (!gate_pullup_o && !gate_pd_fast_o))
        else $error("slow pull-down mode wrong");
    fast_excl_a: assert property (gate_pd_fast_o |-> !gate_pullup_o)
        else $error("pull-up during fast shutdown");
    fast_late_a: assert property ($rose(gate_pd_fast_o) |-> low_q >= FAST_CYCLES && low_q <= FAST_CYCLES + 8)
        else $error("fast shutdown mistimed");
    fast_due_a: assert property (low_q == FAST_CYCLES + 8 |-> gate_pd_fast_o)
        else $error("fast shutdown missing");
    fault_off_a: assert property ((input_overvoltage_i || input_undervoltage_i || mosfet_bad_i)[*4] |=> !gate_pullup_o)
        else $error("gates on during fault");
    pg_low_a: assert property ((pg_mode_i && !output_feedback_ok_i)[*4] |=> power_good_pin_oe_o)
        else $error("power-good pin not low");
    trim_follow_a: assert property (reg_wr_i && reg_addr_i == 8'h11 |=> ilim_sel_o == $past(reg_wdata_i[7:5]))
        else $error("limit select stale");
    gate_write_a: assert property (reg_wr_i && reg_addr_i == 8'h00 && !reg_wdata_i[3] |-> ##2 !gate_pullup_o)
        else $error("gates on while disabled");
    trip_stop_a: assert property ((timer_charge_o && timer_at_hi_i)[*3] |=> !timer_charge_o)
        else $error("timer overcharged");
endmodule
bind hsts_top hsts_top_chk #(.FAST_CYCLES(FAST_CYCLES)) i_chk (
    .clk_i, .sys_rst_i, .input_overvoltage_i, .input_undervoltage_i, .mosfet_bad_i, .timer_at_hi_i,
    .output_feedback_ok_i, .vdd_uvlo_i, .internal_supply_uv_i, .pg_mode_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .gate_pullup_o, .gate_pd_slow_o, .gate_pd_fast_o, .timer_charge_o, .ilim_sel_o,
    .power_good_pin_oe_o);
